/* File: pkg/gate_drive_defines.svh */
// register offsets, field positions, reset values and timing counts
`ifndef GATE_DRIVE_DEFINES_SVH
`define GATE_DRIVE_DEFINES_SVH

`define DRIVE_SETUP_ADDR     3'h6
`define FAULT_FLAGS_ADDR     3'h7
`define DRIVE_SETUP_RESET    12'hfa5
`define FAULT_FLAGS_RESET    6'h00

`define THRESH_LSB           0
`define DEGLITCH_LSB         2
`define SINK_TIME_LSB        4
`define SOURCE_TIME_LSB      6
`define SINK_CURR_LSB        8
`define SOURCE_CURR_LSB      10

`define OVERTEMP_BIT         0
`define CHAN_A_OCP_BIT       1
`define CHAN_B_OCP_BIT       2
`define CHAN_A_PDF_BIT       3
`define CHAN_B_PDF_BIT       4
`define UNDERVOLT_BIT        5

`define FRAME_READ_BIT       15
`define FRAME_ADDR_LSB       12
`define FRAME_BITS           5'h10
`define FRAME_DATA_START     5'h04

`define CLOCK_PERIOD_NS      50
`define DEGLITCH_BASE_NS     1050
`define DEGLITCH_BASE_CYCLES ((`DEGLITCH_BASE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define OFF_STEP_NS          525

`endif

/* File: pkg/gate_drive_pkg.sv */
// shared types of the gate drive register block
package gate_drive_pkg;
    typedef logic [11:0] reg_word_type;
    typedef logic [2:0]  reg_addr_type;
    typedef enum logic [2:0] {
        chop_idle  = 3'b001,
        chop_drive = 3'b010,
        chop_decay = 3'b100
    } chop_state_type;
endpackage

/* File: verilog/spi_frame_port.sv */
// serial frame receiver and read-data shifter
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_defines.svh"
module spi_frame_port (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       scs,
    input  wire logic                       sclk,
    input  wire logic                       sdi,
    input  wire gate_drive_pkg::reg_word_type read_value,
    output gate_drive_pkg::reg_addr_type    peek_addr,
    output logic                            frame_valid,
    output logic [15:0]                     frame_word,
    output logic                            sdo,
    output logic                            sdo_oe_n
);
    import gate_drive_pkg::*;

    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic        sclk_d;
    logic [4:0]  bit_count;
    logic [15:0] shift_in;
    logic [11:0] shift_out;
    logic        scs_s;
    logic        sclk_rise;
    logic        sclk_fall;

    // pins are asynchronous to clock; sclk must stay well below clock/4
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1  <= 3'h0;
            sync2  <= 3'h0;
            sclk_d <= 1'b0;
        end else begin
            sync1  <= {scs, sclk, sdi};
            sync2  <= sync1;
            sclk_d <= sync2[1];
        end
    end

    assign scs_s     = sync2[2];
    assign sclk_rise = sync2[1] & ~sclk_d;
    assign sclk_fall = ~sync2[1] & sclk_d;
    assign peek_addr = shift_in[2:0];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bit_count <= 5'h00;
            shift_in  <= 16'h0000;
        end else if (!scs_s) begin
            bit_count <= 5'h00;
        end else if (sclk_rise && bit_count != `FRAME_BITS) begin
            shift_in  <= {shift_in[14:0], sync2[0]};
            bit_count <= bit_count + 5'h01;
        end
    end

    // a frame cut short by scs falling is dropped without effect
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_valid <= 1'b0;
            frame_word  <= 16'h0000;
        end else begin
            frame_valid <= scs_s && sclk_rise && bit_count == `FRAME_BITS - 5'h01;
            if (scs_s && sclk_rise && bit_count == `FRAME_BITS - 5'h01) begin
                frame_word <= {shift_in[14:0], sync2[0]};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sdo       <= 1'b0;
            shift_out <= 12'h000;
            sdo_oe_n  <= 1'b1;
        end else begin
            sdo_oe_n <= !(scs_s && bit_count >= `FRAME_DATA_START);
            if (!scs_s) begin
                sdo <= 1'b0;
            end else if (sclk_fall && bit_count == `FRAME_DATA_START) begin
                sdo       <= read_value[11];
                shift_out <= {read_value[10:0], 1'b0};
            end else if (sclk_fall && bit_count > `FRAME_DATA_START) begin
                sdo       <= shift_out[11];
                shift_out <= {shift_out[10:0], 1'b0};
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/off_time_chopper.sv */
// fixed off-time decay sequencer for one winding
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_defines.svh"
module off_time_chopper (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       bridge_on,
    input  wire logic       trip,
    input  wire logic [7:0] off_code,
    output logic            decay_active
);
    import gate_drive_pkg::*;

    chop_state_type state;
    logic [17:0]    elapsed_ns;
    logic [17:0]    target_ns;

    // counting in ns rounds the off time up to whole clock periods
    assign target_ns = 18'(({10'h000, off_code} + 18'h0_0001) * 18'(`OFF_STEP_NS));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state      <= chop_idle;
            elapsed_ns <= 18'h0_0000;
        end else if (!bridge_on) begin
            state <= chop_idle;
        end else begin
            unique case (state)
                chop_idle: begin
                    state <= chop_drive;
                end
                chop_drive: begin
                    if (trip) begin
                        state      <= chop_decay;
                        elapsed_ns <= 18'(`CLOCK_PERIOD_NS);
                    end
                end
                chop_decay: begin
                    if (elapsed_ns >= target_ns) begin
                        state <= chop_drive;
                    end else begin
                        elapsed_ns <= elapsed_ns + 18'(`CLOCK_PERIOD_NS);
                    end
                end
            endcase
        end
    end

    assign decay_active = (state == chop_decay);

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_trip_decay: assert property (state == chop_drive && trip && bridge_on |=> decay_active)
        else $error("trip did not start decay");
    a_decay_end: assert property (decay_active && bridge_on && elapsed_ns >= target_ns
        |=> state == chop_drive)
        else $error("drive did not resume after off time");
    a_off_minimum: assert property ($rose(decay_active) |-> (decay_active || !bridge_on)[*8])
        else $error("off time shorter than one step");
    c_decay_done: cover property (decay_active ##1 state == chop_drive);
endmodule
`default_nettype wire

/* File: verilog/gate_drive_config_fault_status.sv */
// gate drive setup and fault flag registers with fault shutdown
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_defines.svh"
// How it works
// - threshold field bits 1-0 picks 250/500/750/1000 mV, reset 01.
// - deglitch field bits 3-2 picks 1.05/2.1/4.2/8.4 us, reset 01.
// - sink time field bits 5-4 picks 263 ns to 2.10 us, reset 10.
// - source time field bits 7-6, same four durations, reset 10.
// - sink current field bits 9-8 picks 100 to 400 mA, reset 11.
// - source current field bits 11-10 picks 50 to 200 mA, reset 11.
// - overtemperature sets bit 0; writing zero clears it; resume needs no write.
// - overtemperature shutdown ends by itself once temperature is safe.
// - overcurrent sets bit 1 or 2 per channel; zero write clears.
// - predriver fault sets bit 3 or 4 per channel; zero write clears.
// - undervoltage sets bit 5; zero write clears except in sleep.
// - undervoltage shutdown ends by itself when supply recovers.
// - status bits 11-6 are reserved and carry nothing.
// - chopping trip during drive starts decay for the fixed off time.
// - a new drive phase starts when the off time has elapsed.
// - chopping current follows the scale setting, gain and sense resistor.
// - any fault present disables both bridges.
// - off time is 525 ns steps times eight-bit code plus one.
// - host programs registers serially; reset loads the defaults.
module gate_drive_config_fault_status (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       scs,
    input  wire logic       sclk,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdo_oe_n,
    input  wire logic       overtemp_detect,
    input  wire logic       undervoltage_detect,
    input  wire logic       sleep_request_pin_n,
    input  wire logic [1:0] overcurrent_cmp,
    input  wire logic [1:0] predriver_fault_detect,
    input  wire logic [1:0] chop_trip_level,
    input  wire logic [7:0] fixed_off_time,
    input  wire logic [7:0] current_scale_setting,
    input  wire logic [1:0] sense_amp_gain_sel,
    output logic [1:0]      overcurrent_threshold_sel,
    output logic [1:0]      overcurrent_deglitch_sel,
    output logic [1:0]      gate_sink_time_sel,
    output logic [1:0]      gate_source_time_sel,
    output logic [1:0]      gate_sink_current_sel,
    output logic [1:0]      gate_source_current_sel,
    output logic [1:0]      bridge_enable,
    output logic [1:0]      decay_active,
    output logic [7:0]      chop_dac_code,
    output logic [1:0]      chop_gain_code,
    output logic            fault_indicator_n
);
    import gate_drive_pkg::*;

    reg_word_type gate_drive_setup;
    logic [5:0]   fault_flags;
    logic [8:0]   pin_sync1;
    logic [8:0]   pin_sync2;
    logic         frame_valid;
    logic [15:0]  frame_word;
    reg_addr_type peek_addr;
    reg_word_type read_value;
    logic         wr_drive;
    logic         wr_status;
    reg_word_type wr_data;
    logic         ot_s;
    logic         uv_s;
    logic         awake_s;
    logic [1:0]   ocp_s;
    logic [1:0]   pdf_s;
    logic [1:0]   trip_s;
    logic [7:0]   deglitch_limit;
    logic [7:0]   ocp_count [2];
    logic [1:0]   ocp_hit;
    logic [5:0]   flag_set;
    logic [5:0]   flag_clear;
    logic         next_bridge_on;

    function automatic logic is_write_to(input logic [15:0] word, input logic valid,
                                         input reg_addr_type addr);
        is_write_to = valid && !word[`FRAME_READ_BIT]
                      && word[`FRAME_ADDR_LSB +: 3] == addr;
    endfunction

    // every status pin and comparator is asynchronous to clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync1 <= 9'h000;
            pin_sync2 <= 9'h000;
        end else begin
            pin_sync1 <= {overtemp_detect, undervoltage_detect, sleep_request_pin_n,
                          overcurrent_cmp, predriver_fault_detect, chop_trip_level};
            pin_sync2 <= pin_sync1;
        end
    end

    assign ot_s    = pin_sync2[8];
    assign uv_s    = pin_sync2[7];
    assign awake_s = pin_sync2[6];
    assign ocp_s   = pin_sync2[5:4];
    assign pdf_s   = pin_sync2[3:2];
    assign trip_s  = pin_sync2[1:0];

    spi_frame_port u_spi (
        .clock       (clock),
        .rst_n       (rst_n),
        .scs         (scs),
        .sclk        (sclk),
        .sdi         (sdi),
        .read_value  (read_value),
        .peek_addr   (peek_addr),
        .frame_valid (frame_valid),
        .frame_word  (frame_word),
        .sdo         (sdo),
        .sdo_oe_n    (sdo_oe_n)
    );

    assign wr_drive  = is_write_to(frame_word, frame_valid, `DRIVE_SETUP_ADDR);
    assign wr_status = is_write_to(frame_word, frame_valid, `FAULT_FLAGS_ADDR);
    assign wr_data   = frame_word[11:0];

    // unmapped and other-block addresses read as zero
    always_comb begin
        read_value = 12'h000;
        if (peek_addr == `DRIVE_SETUP_ADDR) begin
            read_value = gate_drive_setup;
        end else if (peek_addr == `FAULT_FLAGS_ADDR) begin
            read_value = {6'h00, fault_flags};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gate_drive_setup <= `DRIVE_SETUP_RESET;
        end else if (wr_drive) begin
            gate_drive_setup <= wr_data;
        end
    end

    // field slices of the setup register drive the analog gate stage
    assign overcurrent_threshold_sel = gate_drive_setup[`THRESH_LSB +: 2];
    assign overcurrent_deglitch_sel  = gate_drive_setup[`DEGLITCH_LSB +: 2];
    assign gate_sink_time_sel        = gate_drive_setup[`SINK_TIME_LSB +: 2];
    assign gate_source_time_sel      = gate_drive_setup[`SOURCE_TIME_LSB +: 2];
    assign gate_sink_current_sel     = gate_drive_setup[`SINK_CURR_LSB +: 2];
    assign gate_source_current_sel   = gate_drive_setup[`SOURCE_CURR_LSB +: 2];

    // deglitch doubles per code step from the 1.05 us base
    assign deglitch_limit = 8'(`DEGLITCH_BASE_CYCLES) << overcurrent_deglitch_sel;

    for (genvar ch = 0; ch < 2; ch++) begin : g_ocp
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                ocp_count[ch] <= 8'h00;
            end else if (!ocp_s[ch]) begin
                ocp_count[ch] <= 8'h00;
            end else if (ocp_count[ch] != deglitch_limit) begin
                ocp_count[ch] <= ocp_count[ch] + 8'h01;
            end
        end
        assign ocp_hit[ch] = ocp_s[ch] && ocp_count[ch] == deglitch_limit;
    end

    assign flag_set = {uv_s, pdf_s[1], pdf_s[0], ocp_hit[1], ocp_hit[0], ot_s};

    // only zeros clear; ones in the write leave a flag alone
    always_comb begin
        flag_clear = wr_status ? ~wr_data[5:0] : 6'h00;
        flag_clear[`UNDERVOLT_BIT] = flag_clear[`UNDERVOLT_BIT] & awake_s;
    end

    // a condition still present re-sets its flag over a clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fault_flags <= `FAULT_FLAGS_RESET;
        end else begin
            fault_flags <= flag_set | (fault_flags & ~flag_clear);
        end
    end

    // temperature and supply faults follow the live condition
    assign next_bridge_on = awake_s && !ot_s && !uv_s
                            && !(|fault_flags[`CHAN_B_PDF_BIT:`CHAN_A_OCP_BIT]);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bridge_enable     <= 2'b00;
            fault_indicator_n <= 1'b1;
        end else begin
            bridge_enable     <= {2{next_bridge_on}};
            fault_indicator_n <= !(|fault_flags);
        end
    end

    // the dac and sense gain set the trip level; the current is analog
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            chop_dac_code  <= 8'h00;
            chop_gain_code <= 2'b00;
        end else begin
            chop_dac_code  <= current_scale_setting;
            chop_gain_code <= sense_amp_gain_sel;
        end
    end

    for (genvar ch = 0; ch < 2; ch++) begin : g_chop
        off_time_chopper u_chop (
            .clock        (clock),
            .rst_n        (rst_n),
            .bridge_on    (bridge_enable[ch]),
            .trip         (trip_s[ch]),
            .off_code     (fixed_off_time),
            .decay_active (decay_active[ch])
        );
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_setup_write: assert property (wr_drive |=> overcurrent_threshold_sel == $past(wr_data[1:0])
        && gate_source_current_sel == $past(wr_data[11:10]))
        else $error("setup write not applied");
    // bridge is judged one cycle on, since it is registered from the live level seen in the antecedent cycle
    a_ots_sets: assert property (ot_s |=> fault_flags[`OVERTEMP_BIT] && !bridge_enable[0])
        else $error("overtemperature not flagged");
    a_ocp_clear: assert property (wr_status && !wr_data[1] && !ocp_hit[0]
        |=> !fault_flags[`CHAN_A_OCP_BIT])
        else $error("overcurrent flag not cleared");
    a_ones_ignored: assert property (wr_status && fault_flags == 6'h00 && flag_set == 6'h00
        |=> fault_flags == 6'h00)
        else $error("writing ones set a flag");
    a_uv_sleep: assert property (fault_flags[`UNDERVOLT_BIT] && !awake_s && wr_status
        |=> fault_flags[`UNDERVOLT_BIT])
        else $error("undervoltage cleared in sleep");
    a_bridge_off: assert property (|fault_flags[4:1] |=> bridge_enable == 2'b00)
        else $error("bridge on with fault");
    a_auto_resume: assert property (awake_s && !ot_s && !uv_s && fault_flags[4:1] == 4'h0
        |=> bridge_enable == 2'b11)
        else $error("no automatic resume");
    a_reserved_zero: assert property (peek_addr == `FAULT_FLAGS_ADDR |-> read_value[11:6] == 6'h00)
        else $error("reserved status bits nonzero");
    a_deglitch_min: assert property ($rose(fault_flags[`CHAN_A_OCP_BIT]) |-> $past(ocp_s[0], 20))
        else $error("overcurrent flagged before deglitch");
    c_ocp_flag: cover property ($rose(fault_flags[`CHAN_A_OCP_BIT]));
    c_flag_clear: cover property (wr_status ##1 fault_flags == 6'h00);
    c_setup_write: cover property (wr_drive);
endmodule
`default_nettype wire

/* File: verif/spi_host_model.sv */
// host-side serial master that frames register accesses into the block
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic clock,
    input  wire logic sdo,
    input  wire logic sdo_oe_n,
    output logic      scs,
    output logic      sclk,
    output logic      sdi
);
    initial begin
        scs = 1'b0;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    task automatic edge_wait(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    // msb first; sclk idles low between frames; phase is in clock periods, 4 at the least
    task automatic xfer(input logic [15:0] word, input int phase, output logic [11:0] rd,
                        output logic drove);
        rd = 12'h000;
        drove = 1'b1;
        edge_wait(1);
        scs = 1'b1;
        for (int b = 0; b < 16; b++) begin
            sdi = word[15 - b];
            edge_wait(phase);
            // read data only lands after the fourth bit, one bit per falling edge
            if (b >= 4) begin
                rd[15 - b] = sdo;
                drove = drove & ~sdo_oe_n;
            end
            sclk = 1'b1;
            edge_wait(phase);
            sclk = 1'b0;
        end
        edge_wait(phase);
        scs = 1'b0;
        // released line shows no stale bit
        sdi = ~sdi;
        edge_wait(4);
    endtask
endmodule
`default_nettype wire

/* File: verif/gate_drive_config_fault_status_bench.sv */
// self-checking bench for the gate drive setup and fault flag registers
`timescale 1ns/1ps
`default_nettype none
module gate_drive_config_fault_status_bench;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        scs, sclk, sdi, sdo, sdo_oe_n, fault_n, dv;
    logic [5:0]  fault_in = 6'h00;
    logic        sleep_n = 1'b1;
    logic [1:0]  trip = 2'b00;
    logic [7:0]  off_code = 8'h00;
    logic [7:0]  scale = 8'h00;
    logic [1:0]  gain = 2'b00;
    logic [1:0]  thr, deg, snk_t, src_t, snk_i, src_i, bridge, decay, gain_q;
    logic [7:0]  dac_q;
    logic [11:0] rd;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          seed = 32'h2c8d;
    int          m_setup = 12'hfa5;
    int          m_flags = 0;
    int          phase = 4;
    int          n;
    int          offs[$] = '{8'h00, 8'h03, 8'h0a};

    always #25 clock = ~clock;

    spi_host_model i_host (.clock(clock), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .scs(scs), .sclk(sclk), .sdi(sdi));

    gate_drive_config_fault_status i_dut (
        .clock(clock), .rst_n(rst_n), .scs(scs), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .overtemp_detect(fault_in[0]), .undervoltage_detect(fault_in[5]), .sleep_request_pin_n(sleep_n),
        .overcurrent_cmp(fault_in[2:1]), .predriver_fault_detect(fault_in[4:3]), .chop_trip_level(trip),
        .fixed_off_time(off_code), .current_scale_setting(scale), .sense_amp_gain_sel(gain),
        .overcurrent_threshold_sel(thr), .overcurrent_deglitch_sel(deg), .gate_sink_time_sel(snk_t),
        .gate_source_time_sel(src_t), .gate_sink_current_sel(snk_i), .gate_source_current_sel(src_i),
        .bridge_enable(bridge), .decay_active(decay), .chop_dac_code(dac_q), .chop_gain_code(gain_q),
        .fault_indicator_n(fault_n)
    );

    task automatic ticks(input int k);
        repeat (k) @(posedge clock);
        #2;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // flag model: a zero clears unless the cause is live or sleep guards the undervoltage bit
    task automatic wr(input logic [2:0] a, input logic [11:0] d);
        i_host.xfer({1'b0, a, d}, phase, rd, dv);
        if (a == 3'h6) m_setup = d;
        if (a == 3'h7) m_flags = m_flags & (d | fault_in | (sleep_n ? 0 : 32));
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [11:0] exp);
        i_host.xfer({1'b1, a, 12'h000}, phase, rd, dv);
        check(rd, exp);
        check(dv, 1'b1);
    endtask

    task automatic fields;
        check({src_i, snk_i, src_t, snk_t, deg, thr}, m_setup);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        stop_test;
    end

    initial begin
        ticks(16);
        rst_n = 1'b1;
        ticks(6);
        fields;
        rd_chk(3'h6, 12'hfa5);
        rd_chk(3'h7, 12'h000);
        check(bridge, 2'b11);
        $display("test reset_values done");
        // every code in every field, then random words at a slower serial rate
        for (int c = 0; c < 7; c++) begin
            if (c == 4) phase = 9;
            wr(3'h6, c < 4 ? {6{c[1:0]}} : 12'($random(seed)));
            ticks(2);
            fields;
            rd_chk(3'h6, m_setup[11:0]);
        end
        phase = 4;
        wr(3'h5, 12'h000);
        rd_chk(3'h5, 12'h000);
        rd_chk(3'h6, m_setup[11:0]);
        $display("test setup_fields done");
        foreach (offs[i]) for (int ch = 0; ch < 2; ch++) begin
            off_code = offs[i][7:0];
            ticks(2);
            trip[ch] = 1'b1;
            n = 0;
            while (decay[ch] !== 1'b1 && n < 20) begin
                ticks(1);
                n++;
            end
            trip[ch] = 1'b0;
            n = 0;
            while (decay[ch] === 1'b1 && n < 1000) begin
                ticks(1);
                n++;
            end
            check(n, ((offs[i] + 1) * 525 + 49) / 50);
        end
        $display("test chopper done");
        repeat (3) begin
            scale = 8'($random(seed));
            gain = 2'($random(seed));
            ticks(2);
            check({gain_q, dac_q}, {gain, scale});
        end
        $display("test chop_scale done");
        // deglitch code 10: a 70-cycle glitch must not latch on channel b
        wr(3'h6, 12'hffb);
        fault_in[2] = 1'b1;
        ticks(70);
        fault_in[2] = 1'b0;
        ticks(6);
        check({fault_n, bridge}, 3'b111);
        // shortest deglitch: a 15-cycle glitch must not latch
        wr(3'h6, 12'hff3);
        fault_in[1] = 1'b1;
        ticks(15);
        fault_in[1] = 1'b0;
        ticks(6);
        check(bridge, 2'b11);
        for (int k = 0; k < 6; k++) begin
            fault_in[k] = 1'b1;
            ticks(30);
            m_flags |= 1 << k;
            check({fault_n, bridge}, 3'b000);
            wr(3'h7, 12'h000);
            rd_chk(3'h7, m_flags[11:0]);
            fault_in[k] = 1'b0;
            ticks(6);
            check(bridge, (k == 0 || k == 5) ? 2'b11 : 2'b00);
            if (k == 5) sleep_n = 1'b0;
            wr(3'h7, 12'hfff ^ 12'(1 << k));
            rd_chk(3'h7, m_flags[11:0]);
            sleep_n = 1'b1;
            ticks(4);
            wr(3'h7, 12'h000);
            check({fault_n, bridge}, 3'b111);
        end
        $display("test fault_flags done");
        wr(3'h6, 12'h000);
        rst_n = 1'b0;
        ticks(2);
        rst_n = 1'b1;
        m_setup = 12'hfa5;
        ticks(4);
        fields;
        rd_chk(3'h6, 12'hfa5);
        $display("test second_reset done");
        stop_test;
    end
endmodule
`default_nettype wire
